// file: rtl/cascade_bus_defines.svh
// constants for the cascade and output bus port
`ifndef CASCADE_BUS_DEFINES_SVH
`define CASCADE_BUS_DEFINES_SVH
`define BUS_W 20
`define BUS_MSB 19
`define SAT_MAX 20'h7FFFF
`define SAT_MIN 20'h80000
`define ZERO_BUS 20'h00000
`endif

// file: rtl/cascade_bus_pkg.sv
// types for the cascade and output bus port
package cascade_bus_pkg;
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_CASCADE_IN,
    MODE_MUX_IQ
  } out_mode_t;
endpackage : cascade_bus_pkg

// file: rtl/sat_adder.sv
// saturating two's-complement adder for one output summer
`timescale 1ns/1ps
`include "cascade_bus_defines.svh"
module sat_adder (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [`BUS_MSB:0] a,
  input wire logic [`BUS_MSB:0] b,
  output logic [`BUS_MSB:0] sum_reg
);
  logic [`BUS_W:0] wide;
  logic [`BUS_MSB:0] sum_next;
  always_comb begin
    wide = {a[`BUS_MSB], a} + {b[`BUS_MSB], b};
    // sign bits disagree only when the sum overflowed
    if (wide[`BUS_W] != wide[`BUS_MSB]) begin
      sum_next = wide[`BUS_W] ? `SAT_MIN : `SAT_MAX;
    end else begin
      sum_next = wide[`BUS_MSB:0];
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sum_reg <= `ZERO_BUS;
    end else begin
      sum_reg <= sum_next;
    end
  end
endmodule : sat_adder

// file: rtl/cascade_output_bus_port.sv
// dual-purpose cascade input / output buses c and d
// Contract
// - both buses are inputs in cascade-in mode, outputs otherwise.
// - i cascade samples are two's complement, captured every rising edge.
// - q cascade samples are two's complement, captured every rising edge.
// - i cascade feeds summer 1, q cascade feeds summer 2.
// - bus c carries summer 3 samples, updated each rising edge.
// - bus d carries summer 4 samples, updated each rising edge.
// - in muxed i/q mode strobe is high while buses carry i data.
// - summers add cascade input to local signal with saturation.
`timescale 1ns/1ps
`include "cascade_bus_defines.svh"
module cascade_output_bus_port
  import cascade_bus_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire out_mode_t out_mode,
  input wire logic [`BUS_MSB:0] local_sum1,
  input wire logic [`BUS_MSB:0] local_sum2,
  input wire logic [`BUS_MSB:0] summer3_data,
  input wire logic [`BUS_MSB:0] summer4_data,
  input wire logic summer_is_i,
  input wire logic [`BUS_MSB:0] i_cascade_or_bus_c_in,
  output logic [`BUS_MSB:0] i_cascade_or_bus_c_out,
  output logic i_cascade_or_bus_c_oe_b,
  input wire logic [`BUS_MSB:0] q_cascade_or_bus_d_in,
  output logic [`BUS_MSB:0] q_cascade_or_bus_d_out,
  output logic q_cascade_or_bus_d_oe_b,
  output logic [`BUS_MSB:0] summer1_out,
  output logic [`BUS_MSB:0] summer2_out,
  output logic i_data_valid_strobe
);
  // ************************************************
  // mode register and bus direction
  // ************************************************
  out_mode_t mode_reg;
  logic [`BUS_MSB:0] i_cap_reg;
  logic [`BUS_MSB:0] q_cap_reg;
  logic cascade_in;
  assign cascade_in = (mode_reg == MODE_CASCADE_IN);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= MODE_CASCADE_IN;
    end else begin
      mode_reg <= out_mode;
    end
  end

  // enables follow the registered mode, so a turnaround costs two edges from out_mode;
  // reset leaves both buses released to avoid contention
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      i_cascade_or_bus_c_oe_b <= 1'b1;
      q_cascade_or_bus_d_oe_b <= 1'b1;
    end else begin
      i_cascade_or_bus_c_oe_b <= cascade_in;
      q_cascade_or_bus_d_oe_b <= cascade_in;
    end
  end

  // ************************************************
  // cascade capture
  // ************************************************
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      i_cap_reg <= `ZERO_BUS;
      q_cap_reg <= `ZERO_BUS;
    end else if (cascade_in) begin
      i_cap_reg <= i_cascade_or_bus_c_in;
      q_cap_reg <= q_cascade_or_bus_d_in;
    end else begin
      // not cascading: summers see zero so the local signal passes
      i_cap_reg <= `ZERO_BUS;
      q_cap_reg <= `ZERO_BUS;
    end
  end

  // ************************************************
  // summers 1 and 2
  // ************************************************
  sat_adder u_sum1 (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .a(local_sum1),
    .b(i_cap_reg),
    .sum_reg(summer1_out)
  );
  sat_adder u_sum2 (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .a(local_sum2),
    .b(q_cap_reg),
    .sum_reg(summer2_out)
  );

  // ************************************************
  // output buses c and d, strobe
  // ************************************************
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      i_cascade_or_bus_c_out <= `ZERO_BUS;
      q_cascade_or_bus_d_out <= `ZERO_BUS;
    end else begin
      i_cascade_or_bus_c_out <= summer3_data;
      q_cascade_or_bus_d_out <= summer4_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      i_data_valid_strobe <= 1'b0;
    end else begin
      i_data_valid_strobe <= (mode_reg == MODE_MUX_IQ) && summer_is_i;
    end
  end

  // ************************************************
  // assertions
  // ************************************************
  property p_dir;
    @(posedge core_clk) disable iff (!rst_b)
      ##1 (i_cascade_or_bus_c_oe_b == $past(cascade_in)) &&
          (q_cascade_or_bus_d_oe_b == $past(cascade_in));
  endproperty
  a_dir: assert property (p_dir) else $error("bus direction wrong");

  sequence s_mode_change;
    out_mode != mode_reg;
  endsequence
  property p_no_early_switch;
    @(posedge core_clk) disable iff (!rst_b)
      s_mode_change |=> $stable(i_cascade_or_bus_c_oe_b);
  endproperty
  a_no_early_switch: assert property (p_no_early_switch)
    else $error("driver switched before mode registered");

  property p_icap;
    @(posedge core_clk) disable iff (!rst_b)
      cascade_in |=> i_cap_reg == $past(i_cascade_or_bus_c_in);
  endproperty
  a_icap: assert property (p_icap) else $error("i capture wrong");

  property p_qcap;
    @(posedge core_clk) disable iff (!rst_b)
      cascade_in |=> q_cap_reg == $past(q_cascade_or_bus_d_in);
  endproperty
  a_qcap: assert property (p_qcap) else $error("q capture wrong");

  property p_bus_c;
    @(posedge core_clk) disable iff (!rst_b)
      ##1 i_cascade_or_bus_c_out == $past(summer3_data);
  endproperty
  a_bus_c: assert property (p_bus_c) else $error("bus c data wrong");

  property p_bus_d;
    @(posedge core_clk) disable iff (!rst_b)
      ##1 q_cascade_or_bus_d_out == $past(summer4_data);
  endproperty
  a_bus_d: assert property (p_bus_d) else $error("bus d data wrong");

  property p_strobe;
    @(posedge core_clk) disable iff (!rst_b)
      ##1 i_data_valid_strobe ==
        ($past(mode_reg == MODE_MUX_IQ) && $past(summer_is_i));
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe wrong");

  property p_sat1;
    @(posedge core_clk) disable iff (!rst_b)
      (!local_sum1[`BUS_MSB] && !i_cap_reg[`BUS_MSB]) |=>
        !summer1_out[`BUS_MSB];
  endproperty
  a_sat1: assert property (p_sat1) else $error("summer 1 wrapped");

  property p_path2;
    @(posedge core_clk) disable iff (!rst_b)
      ##2 (!$past(cascade_in, 2) && !$past(local_sum2[`BUS_MSB], 1)) |->
        summer2_out == $past(local_sum2);
  endproperty
  a_path2: assert property (p_path2) else $error("summer 2 path wrong");

  // adding zero can never overflow, so no sign condition is needed here
  property p_path1;
    @(posedge core_clk) disable iff (!rst_b)
      ##2 !$past(cascade_in, 2) |-> summer1_out == $past(local_sum1);
  endproperty
  a_path1: assert property (p_path1) else $error("summer 1 path wrong");

  property p_cap_zero;
    @(posedge core_clk) disable iff (!rst_b)
      !cascade_in |=>
        (i_cap_reg == `ZERO_BUS) && (q_cap_reg == `ZERO_BUS);
  endproperty
  a_cap_zero: assert property (p_cap_zero)
    else $error("capture not zero outside cascade-in");

  property p_oe_pair;
    @(posedge core_clk) disable iff (!rst_b)
      i_cascade_or_bus_c_oe_b == q_cascade_or_bus_d_oe_b;
  endproperty
  a_oe_pair: assert property (p_oe_pair)
    else $error("bus enables differ");

  property p_sat1_low;
    @(posedge core_clk) disable iff (!rst_b)
      (local_sum1[`BUS_MSB] && i_cap_reg[`BUS_MSB]) |=>
        summer1_out[`BUS_MSB];
  endproperty
  a_sat1_low: assert property (p_sat1_low)
    else $error("summer 1 wrapped negative");

  property p_sat2;
    @(posedge core_clk) disable iff (!rst_b)
      (!local_sum2[`BUS_MSB] && !q_cap_reg[`BUS_MSB]) |=>
        !summer2_out[`BUS_MSB];
  endproperty
  a_sat2: assert property (p_sat2) else $error("summer 2 wrapped");

  property p_sat2_low;
    @(posedge core_clk) disable iff (!rst_b)
      (local_sum2[`BUS_MSB] && q_cap_reg[`BUS_MSB]) |=>
        summer2_out[`BUS_MSB];
  endproperty
  a_sat2_low: assert property (p_sat2_low)
    else $error("summer 2 wrapped negative");

  // turnaround in both directions: the enable moves one edge after the
  // registered mode, never in the same edge as the mode input
  sequence s_leave_cascade;
    cascade_in && (out_mode != MODE_CASCADE_IN);
  endsequence
  sequence s_release_then_drive;
    i_cascade_or_bus_c_oe_b ##1 !i_cascade_or_bus_c_oe_b;
  endsequence
  property p_leave_cascade;
    @(posedge core_clk) disable iff (!rst_b)
      s_leave_cascade |=> s_release_then_drive;
  endproperty
  a_leave_cascade: assert property (p_leave_cascade)
    else $error("bus c driven before cascade-in was left");

  sequence s_enter_cascade;
    !cascade_in && (out_mode == MODE_CASCADE_IN);
  endsequence
  sequence s_drive_then_release;
    !i_cascade_or_bus_c_oe_b ##1 i_cascade_or_bus_c_oe_b;
  endsequence
  property p_enter_cascade;
    @(posedge core_clk) disable iff (!rst_b)
      s_enter_cascade |=> s_drive_then_release;
  endproperty
  a_enter_cascade: assert property (p_enter_cascade)
    else $error("bus c released at the wrong edge");
endmodule : cascade_output_bus_port

// file: sim/upstream_model.sv
// upstream cascade source model
`timescale 1ns/1ps
module upstream_model (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic drive_en,
  input wire logic [19:0] i_val,
  input wire logic [19:0] q_val,
  output logic [19:0] i_drv,
  output logic [19:0] q_drv
);
  // released bus toggles so a stale sample can never pass as valid
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      i_drv <= 20'h00000;
      q_drv <= 20'h00000;
    end else if (drive_en) begin
      i_drv <= i_val;
      q_drv <= q_val;
    end else begin
      i_drv <= ~i_drv;
      q_drv <= ~q_drv;
    end
  end
endmodule : upstream_model

// file: sim/tb_cascade_output_bus_port.sv
// self-checking bench for the cascade and output bus port
`timescale 1ns/1ps
module tb_cascade_output_bus_port import cascade_bus_pkg::*;;
  logic core_clk = 0, rst_b = 0, is_i = 0;
  out_mode_t mode = MODE_CASCADE_IN;
  logic [19:0] l1 = 0, l2 = 0, s3 = 0, s4 = 0, ci = 0, cq = 0;
  logic [19:0] c_out, d_out, c_w, d_w, p_i, p_q, sum1, sum2;
  logic c_oe_b, d_oe_b, strobe;
  int err_count = 0, n_checks = 0;
  always #25 core_clk = ~core_clk;
  // upstream only drives while the port has released the wire
  assign c_w = c_oe_b ? p_i : c_out;
  assign d_w = d_oe_b ? p_q : d_out;
  upstream_model u_up (.core_clk(core_clk), .rst_b(rst_b),
    .drive_en(c_oe_b), .i_val(ci), .q_val(cq), .i_drv(p_i), .q_drv(p_q));
  cascade_output_bus_port u_dut (.core_clk(core_clk), .rst_b(rst_b),
    .out_mode(mode), .local_sum1(l1), .local_sum2(l2), .summer3_data(s3),
    .summer4_data(s4), .summer_is_i(is_i), .i_cascade_or_bus_c_in(c_w),
    .i_cascade_or_bus_c_out(c_out), .i_cascade_or_bus_c_oe_b(c_oe_b),
    .q_cascade_or_bus_d_in(d_w), .q_cascade_or_bus_d_out(d_out),
    .q_cascade_or_bus_d_oe_b(d_oe_b), .summer1_out(sum1),
    .summer2_out(sum2), .i_data_valid_strobe(strobe));
  // ****************************************
  // checks and scenarios
  // ****************************************
  task automatic chk_bus(string nm, logic [19:0] e, logic [19:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk_bus
  task automatic chk_bit(string nm, logic e, logic g);
    chk_bus(nm, {19'h00000, e}, {19'h00000, g});
  endtask : chk_bit
  task automatic run(int n);
    repeat (n) @(posedge core_clk);
    #5;
  endtask : run
  task automatic t_cascade(logic [19:0] a, b, x, y, e1, e2);
    mode = MODE_CASCADE_IN;
    {l1, l2, ci, cq} = {a, b, x, y};
    run(5);
    chk_bit("c_oe_b", 1'b1, c_oe_b);
    chk_bit("d_oe_b", 1'b1, d_oe_b);
    chk_bus("sum1", e1, sum1);
    chk_bus("sum2", e2, sum2);
  endtask : t_cascade
  task automatic t_out(out_mode_t m, logic iq, logic e_stb);
    mode = m;
    {is_i, s3, s4, ci, l1} = {iq, 20'h12345, 20'hABCDE, 20'h00111, 20'h00007};
    l2 = 20'h00009;
    run(4);
    chk_bit("c_oe_b", 1'b0, c_oe_b);
    chk_bit("d_oe_b", 1'b0, d_oe_b);
    chk_bus("sum2", 20'h00009, sum2);
    chk_bus("bus_c", 20'h12345, c_w);
    chk_bus("bus_d", 20'hABCDE, d_w);
    chk_bus("sum1", 20'h00007, sum1);
    chk_bit("strobe", e_stb, strobe);
  endtask : t_out
  task automatic t_switch;
    mode = MODE_NORMAL;
    run(1);
    chk_bit("c_oe_b", 1'b1, c_oe_b);
    run(1);
    chk_bit("c_oe_b", 1'b0, c_oe_b);
    chk_bit("d_oe_b", 1'b0, d_oe_b);
  endtask : t_switch
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  initial begin
    #20000;
    err_count++;
    complete_run();
  end
  initial begin
    run(8);
    chk_bit("c_oe_b", 1'b1, c_oe_b);
    chk_bit("strobe", 1'b0, strobe);
    rst_b = 1;
    t_cascade(20'h00005, 20'h00003, 20'h00010, 20'hFFFF0,
      20'h00015, 20'hFFFF3);
    t_cascade(20'h00001, 20'hFFFFF, 20'h7FFFF, 20'h80000,
      20'h7FFFF, 20'h80000);
    t_out(MODE_NORMAL, 1'b1, 1'b0);
    t_out(MODE_MUX_IQ, 1'b1, 1'b1);
    t_out(MODE_MUX_IQ, 1'b0, 1'b0);
    t_cascade(20'h80001, 20'h7FFFE, 20'hFFFFE, 20'h00003,
      20'h80000, 20'h7FFFF);
    t_switch();
    complete_run();
  end
endmodule : tb_cascade_output_bus_port
